/* hdl/rrnfo_pkg.sv */
// shared constants, types and decode functions of the rotate and fill executor
`default_nettype none
package rrnfo_pkg;
    // instruction word layout
    localparam int unsigned WORD_W = 16;
    localparam int unsigned ROT_OPC_HI = 15;
    localparam int unsigned ROT_OPC_LO = 10;
    localparam logic [5:0] ROT_OPC = 6'h10;
    localparam int unsigned FILL_OPC_HI = 15;
    localparam int unsigned FILL_OPC_LO = 9;
    localparam logic [6:0] FILL_OPC = 7'h34;
    localparam int unsigned DEST_BIT = 9;
    localparam int unsigned BANK_BIT = 8;
    localparam int unsigned FADDR_W = 8;
    // data path and address space
    localparam int unsigned DATA_W = 8;
    localparam int unsigned BANK_W = 4;
    localparam int unsigned ADDR_W = 12;
    localparam logic [7:0] FILL_VALUE = 8'hFF;
    // access bank split: low half to the first bank, high half to the last
    localparam logic [7:0] ACCESS_SPLIT = 8'h80;
    localparam logic [3:0] ACCESS_LO_BANK = 4'h0;
    localparam logic [3:0] ACCESS_HI_BANK = 4'hF;
    // reset values
    localparam logic [11:0] ADDR_RST = 12'h000;
    localparam logic [7:0] DATA_RST = 8'h00;
    localparam logic [15:0] WORD_RST = 16'h0000;

    typedef enum logic [3:0] {
        PH_Q1 = 4'b0001,
        PH_Q2 = 4'b0010,
        PH_Q3 = 4'b0100,
        PH_Q4 = 4'b1000
    } rrnfo_phase_type;

    typedef struct packed {
        logic valid;
        logic [15:0] word;
    } rrnfo_instr_type;

    typedef struct packed {
        logic en;
        logic [11:0] addr;
    } rrnfo_fread_type;

    typedef struct packed {
        logic en;
        logic [11:0] addr;
        logic [7:0] data;
    } rrnfo_fwrite_type;

    typedef struct packed {
        logic en;
        logic [7:0] data;
    } rrnfo_acc_type;

    function automatic logic rrnfo_is_rot(input logic [15:0] w);
        return w[ROT_OPC_HI:ROT_OPC_LO] == ROT_OPC;
    endfunction

    function automatic logic rrnfo_is_fill(input logic [15:0] w);
        return w[FILL_OPC_HI:FILL_OPC_LO] == FILL_OPC;
    endfunction

    function automatic logic [7:0] rrnfo_rotr(input logic [7:0] v);
        return {v[0], v[7:1]};
    endfunction
endpackage
`default_nettype wire

/* hdl/rrnfo_addr_map.sv */
// maps an 8-bit file address and bank-select bit onto the full file address
`default_nettype none
module rrnfo_addr_map
    import rrnfo_pkg::*;
(
    // operand
    input wire logic [7:0] faddr,
    input wire logic bank_sel,
    // bank select register contents
    input wire logic [3:0] bank_select_register,
    // result
    output logic [11:0] full_addr
);
    // access bank ignores the bank select register entirely
    always_comb begin
        if (!bank_sel) begin
            full_addr = (faddr < ACCESS_SPLIT) ? {ACCESS_LO_BANK, faddr}
                                               : {ACCESS_HI_BANK, faddr};
        end else begin
            full_addr = {bank_select_register, faddr};
        end
    end
endmodule
`default_nettype wire

/* hdl/rrnfo_exec.sv */
// rotate-right-no-carry and fill-ones executor, four phases per instruction cycle
// Functional notes
// - rotate moves bit n to n-1 and bit 0 to bit 7, carry untouched
// - rotate recognised by top bits 0100 00, then d, a, 8-bit address
// - d=0: rotated result goes to accumulator, file register left alone
// - d=1: rotated result written back to the addressed file register
// - a=0 selects access bank; a=1 uses bank select register
// - fill opcode 0110 100a writes FFh to file register, no flags changed
`default_nettype none
module rrnfo_exec
    import rrnfo_pkg::*;
(
    // clock and reset
    input wire logic clk_sys,
    input wire logic rstn,
    // instruction from the fetch stage, sampled in the decode phase
    input wire rrnfo_pkg::rrnfo_instr_type instr,
    input wire logic [3:0] bank_select_register,
    // register file read port, data returned in the same cycle
    output var rrnfo_pkg::rrnfo_fread_type fread,
    input wire logic [7:0] rd_data,
    // register file write port and accumulator write
    output var rrnfo_pkg::rrnfo_fwrite_type fwrite,
    output var rrnfo_pkg::rrnfo_acc_type acc_wr,
    // phase and completion
    output var rrnfo_pkg::rrnfo_phase_type phase,
    output logic done
);
    import rrnfo_pkg::*;

    rrnfo_phase_type phase_q, phase_d;
    logic rot_q, rot_d, fill_q, fill_d, dest_q, dest_d;
    logic [11:0] addr_q, addr_d;
    logic [7:0] data_q, data_d;
    rrnfo_fread_type fread_q, fread_d;
    rrnfo_fwrite_type fwrite_q, fwrite_d;
    rrnfo_acc_type acc_q, acc_d;
    logic done_q, done_d;
    logic [11:0] map_addr;
    logic take;

    // bank resolution of the incoming operand address
    rrnfo_addr_map u_map (
        .faddr(instr.word[FADDR_W-1:0]),
        .bank_sel(instr.word[BANK_BIT]),
        .bank_select_register(bank_select_register),
        .full_addr(map_addr)
    );

    // instruction only enters in the decode phase; anything else is ignored
    assign take = (phase_q == PH_Q1) && instr.valid;

    // phase sequencer and data path next state
    always_comb begin
        phase_d = phase_q;
        rot_d = rot_q;
        fill_d = fill_q;
        dest_d = dest_q;
        addr_d = addr_q;
        data_d = data_q;
        fread_d = '{en: 1'b0, addr: fread_q.addr};
        fwrite_d = '{en: 1'b0, addr: fwrite_q.addr, data: fwrite_q.data};
        acc_d = '{en: 1'b0, data: acc_q.data};
        done_d = 1'b0;
        unique case (phase_q)
            PH_Q1: begin // decode
                phase_d = PH_Q2;
                rot_d = take && rrnfo_is_rot(instr.word);
                fill_d = take && rrnfo_is_fill(instr.word);
                dest_d = instr.word[DEST_BIT];
                addr_d = map_addr;
                // fill needs no read, so the port stays quiet for it
                fread_d = '{en: rot_d, addr: map_addr};
            end
            PH_Q2: begin // read register
                phase_d = PH_Q3;
                data_d = rd_data;
            end
            PH_Q3: begin // process; fill ignores the read value
                phase_d = PH_Q4;
                data_d = fill_q ? FILL_VALUE : rrnfo_rotr(data_q);
                // no flag output exists here, so fill cannot disturb status
                fwrite_d = '{en: fill_q || (rot_q && dest_q), addr: addr_q,
                             data: data_d};
                acc_d = '{en: rot_q && !dest_q, data: data_d};
                done_d = rot_q || fill_q;
            end
            PH_Q4: begin // write destination
                phase_d = PH_Q1;
                rot_d = 1'b0;
                fill_d = 1'b0;
            end
        endcase
    end

    // state registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            phase_q <= PH_Q1;
            rot_q <= 1'b0;
            fill_q <= 1'b0;
            dest_q <= 1'b0;
            addr_q <= ADDR_RST;
            data_q <= DATA_RST;
            fread_q <= '{en: 1'b0, addr: ADDR_RST};
            fwrite_q <= '{en: 1'b0, addr: ADDR_RST, data: DATA_RST};
            acc_q <= '{en: 1'b0, data: DATA_RST};
            done_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            rot_q <= rot_d;
            fill_q <= fill_d;
            dest_q <= dest_d;
            addr_q <= addr_d;
            data_q <= data_d;
            fread_q <= fread_d;
            fwrite_q <= fwrite_d;
            acc_q <= acc_d;
            done_q <= done_d;
        end
    end

    // outputs straight from the flops
    assign phase = phase_q;
    assign fread = fread_q;
    assign fwrite = fwrite_q;
    assign acc_wr = acc_q;
    assign done = done_q;

    // helper terms for the checks below
    logic [7:0] rot_of_rd;
    logic take_rot, take_fill;
    assign rot_of_rd = rrnfo_rotr(rd_data);
    assign take_rot = take && rrnfo_is_rot(instr.word);
    assign take_fill = take && rrnfo_is_fill(instr.word);

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    property p_rot_value;
        fread_q.en |-> ##2 ((fwrite_q.en && fwrite_q.data == $past(rot_of_rd, 2))
                            || (acc_q.en && acc_q.data == $past(rot_of_rd, 2)));
    endproperty
    a_rot_value: assert property (p_rot_value) else $error("rotate result wrong");

    property p_rot_decode;
        take_rot |=> fread_q.en && fread_q.addr == $past(map_addr);
    endproperty
    a_rot_decode: assert property (p_rot_decode) else $error("rotate not decoded");

    property p_dest_acc;
        take_rot && !instr.word[DEST_BIT] |-> ##3 (acc_q.en && !fwrite_q.en);
    endproperty
    a_dest_acc: assert property (p_dest_acc) else $error("d=0 not to acc");

    property p_dest_file;
        take_rot && instr.word[DEST_BIT] |-> ##3
            (fwrite_q.en && !acc_q.en && fwrite_q.addr == $past(map_addr, 3));
    endproperty
    a_dest_file: assert property (p_dest_file) else $error("d=1 not to file");

    property p_access_bank;
        (take_rot || take_fill) && !instr.word[BANK_BIT] |=>
            addr_q[11:8] == (addr_q[7:0] < ACCESS_SPLIT ? ACCESS_LO_BANK : ACCESS_HI_BANK);
    endproperty
    a_access_bank: assert property (p_access_bank) else $error("access bank wrong");

    property p_bank_reg_used;
        (take_rot || take_fill) && instr.word[BANK_BIT] |=>
            addr_q[11:8] == $past(bank_select_register);
    endproperty
    a_bank_reg_used: assert property (p_bank_reg_used) else $error("bank select ignored");

    property p_fill;
        take_fill |-> ##1 !fread_q.en ##2 (fwrite_q.en && fwrite_q.data == FILL_VALUE
                                            && !acc_q.en);
    endproperty
    a_fill: assert property (p_fill) else $error("fill wrong");

    property p_one_cycle;
        (take_rot || take_fill) |-> !done_q [*3] ##1 (done_q && phase_q == PH_Q4);
    endproperty
    a_one_cycle: assert property (p_one_cycle) else $error("not one cycle");

    property p_write_q4;
        (fwrite_q.en || acc_q.en) |-> phase_q == PH_Q4 && $past(phase_q) == PH_Q3;
    endproperty
    a_write_q4: assert property (p_write_q4) else $error("write outside Q4");

    // an opcode matching neither pattern must leave every port quiet
    property p_ignore_other;
        take && !take_rot && !take_fill |=>
            !fread_q.en ##2 (!fwrite_q.en && !acc_q.en && !done_q);
    endproperty
    a_ignore_other: assert property (p_ignore_other) else $error("unknown opcode acted on");

    // the read strobe only ever lands in the read phase
    property p_read_q2;
        fread_q.en |-> phase_q == PH_Q2;
    endproperty
    a_read_q2: assert property (p_read_q2) else $error("read outside Q2");

    // d picks exactly one destination, never both at once
    property p_one_dest;
        !(fwrite_q.en && acc_q.en);
    endproperty
    a_one_dest: assert property (p_one_dest) else $error("two destinations written");

    // done is a single pulse, so the core cannot count one instruction twice
    property p_done_pulse;
        done_q |=> !done_q;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done too long");

    // the phase ring runs free and never skips, instruction or not
    property p_phase_ring;
        phase_q == PH_Q1 |=> phase_q == PH_Q2 ##1 phase_q == PH_Q3 ##1 phase_q == PH_Q4
            ##1 phase_q == PH_Q1;
    endproperty
    a_phase_ring: assert property (p_phase_ring) else $error("phase ring broken");

    // main scenarios, including an offered word that decodes to nothing
    c_ignored: cover property (take && !take_rot && !take_fill ##3 !done_q);

    c_rot_acc: cover property (take_rot && !instr.word[DEST_BIT] ##3 acc_q.en);
    c_rot_file: cover property (take_rot && instr.word[DEST_BIT] ##3 fwrite_q.en);
    c_fill: cover property (take_fill ##3 fwrite_q.en);
    c_back_to_back: cover property (done_q ##1 take_rot ##3 done_q);
endmodule
`default_nettype wire

/* dv/rrnfo_regfile_model.sv */
// behavioural register file and accumulator facing the executor
`default_nettype none
module rrnfo_regfile_model
    import rrnfo_pkg::*;
(
    // clock
    input wire logic clk_sys,
    // read port
    input wire rrnfo_pkg::rrnfo_fread_type fread,
    output logic [7:0] rd_data,
    // write ports
    input wire rrnfo_pkg::rrnfo_fwrite_type fwrite,
    input wire rrnfo_pkg::rrnfo_acc_type acc_wr,
    output logic [7:0] acc_q
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0] mem [0:4095];
    logic [7:0] last_q = 8'h00;

    // data only valid under the strobe; otherwise a value that keeps changing
    always_comb rd_data = fread.en ? mem[fread.addr] : ~last_q;

    // plain always so the bench may preload the array and accumulator
    always @(posedge clk_sys) begin
        last_q <= fread.en ? mem[fread.addr] : ~last_q;
        if (fwrite.en) mem[fwrite.addr] <= fwrite.data;
        if (acc_wr.en) acc_q <= acc_wr.data;
    end
endmodule
`default_nettype wire

/* dv/testbench.sv */
// self-checking bench of the rotate and fill executor
`default_nettype none
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import rrnfo_pkg::*;

    logic clk_sys = 1'b0;
    logic rstn = 1'b0;
    rrnfo_instr_type instr = '0;
    logic [3:0] bank_reg = 4'h0;
    rrnfo_fread_type fread;
    rrnfo_fwrite_type fwrite;
    rrnfo_acc_type acc_wr;
    rrnfo_phase_type phase;
    logic done;
    logic [7:0] rd_data;
    logic [7:0] acc_q;
    int n_errors = 0;
    int n_compared = 0;
    int cyc = 0;

    // 125 MHz system clock
    always #4 clk_sys = ~clk_sys;

    rrnfo_exec DUT (.clk_sys(clk_sys), .rstn(rstn), .instr(instr),
        .bank_select_register(bank_reg), .fread(fread), .rd_data(rd_data), .fwrite(fwrite),
        .acc_wr(acc_wr), .phase(phase), .done(done));
    rrnfo_regfile_model REGS (.clk_sys(clk_sys), .fread(fread), .rd_data(rd_data),
        .fwrite(fwrite), .acc_wr(acc_wr), .acc_q(acc_q));

    task automatic report_and_stop;
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    // hang guard, the whole run needs well under a hundred cycles
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 2000) begin
            n_errors++;
            report_and_stop();
        end
    end

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_errors++;
            $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    // expected full address, worked out independently of the design
    function automatic logic [11:0] map(input logic a, input logic [7:0] f, input logic [3:0] b);
        if (a) return {b, f};
        return {(f < 8'h80) ? 4'h0 : 4'hF, f};
    endfunction

    // kind: 0 ignored, 1 rotate to file, 2 rotate to accumulator, 3 fill
    task automatic exec(input logic [15:0] w, input logic [3:0] b, input int kind);
        logic [11:0] ad;
        ad = map(w[8], w[7:0], b);
        instr = '{valid: 1'b1, word: w};
        bank_reg = b;
        @(posedge clk_sys); #1;
        instr.valid = 1'b0;
        bank_reg = ~b; // bank is only looked at in decode
        check(phase, PH_Q2);
        check(fread.en, kind == 1 || kind == 2);
        if (fread.en === 1'b1) check(fread.addr, ad);
        @(posedge clk_sys); #1;
        @(posedge clk_sys); #1;
        check(done, kind != 0);
        check(phase, PH_Q4);
        check(fwrite.en, kind == 1 || kind == 3);
        check(acc_wr.en, kind == 2);
        if (fwrite.en === 1'b1) check(fwrite.addr, ad);
        @(posedge clk_sys); #1;
        check(done, 1'b0);
    endtask

    task automatic t_rot_file;
        REGS.acc_q = 8'h3C;
        REGS.mem[12'h021] = 8'hD7;
        REGS.mem[12'hF90] = 8'h01;
        exec(16'h4221, 4'h5, 1);
        exec(16'h4290, 4'h5, 1); // back to back, high half of access bank
        check(REGS.mem[12'h021], 8'hEB);
        check(REGS.mem[12'hF90], 8'h80);
        check(acc_q, 8'h3C);
        $display("test rot_file done");
    endtask

    task automatic t_rot_acc;
        REGS.mem[12'h344] = 8'hD7;
        exec(16'h4144, 4'h3, 2);
        check(acc_q, 8'hEB);
        check(REGS.mem[12'h344], 8'hD7);
        $display("test rot_acc done");
    endtask

    task automatic t_fill;
        REGS.mem[12'hA10] = 8'h5A;
        REGS.mem[12'hFFE] = 8'h00;
        exec(16'h6910, 4'hA, 3);
        exec(16'h68FE, 4'hA, 3);
        check(REGS.mem[12'hA10], 8'hFF);
        check(REGS.mem[12'hFFE], 8'hFF);
        check(acc_q, 8'hEB);
        $display("test fill done");
    endtask

    task automatic t_ignore;
        REGS.mem[12'h021] = 8'h11;
        exec(16'h4621, 4'h0, 0); // neighbouring opcode
        exec(16'h6A21, 4'h0, 0);
        // exec leaves us in Q1; step into Q2 so the offer spans Q2 to Q4 only
        @(posedge clk_sys); #1;
        instr = '{valid: 1'b1, word: 16'h4221}; // offered outside decode
        repeat (3) begin
            @(posedge clk_sys); #1;
            check(done, 1'b0);
            check(fread.en, 1'b0);
        end
        instr.valid = 1'b0;
        @(posedge clk_sys); #1;
        check(REGS.mem[12'h021], 8'h11);
        $display("test ignore done");
    endtask

    // reset pulled in the middle of a rotate: that cycle is abandoned, the next one runs
    task automatic t_reset;
        while (phase !== PH_Q1) begin
            @(posedge clk_sys); #1;
        end
        REGS.mem[12'h055] = 8'h96;
        instr = '{valid: 1'b1, word: 16'h4255};
        @(posedge clk_sys); #1;
        instr.valid = 1'b0;
        check(fread.en, 1'b1);
        rstn = 1'b0;
        // three edges cover the one at which the abandoned write would have landed
        repeat (3) begin
            @(posedge clk_sys); #1;
            check(phase, PH_Q1);
            check(fread.en | fwrite.en | acc_wr.en | done, 1'b0);
        end
        check(REGS.mem[12'h055], 8'h96);
        rstn = 1'b1;
        exec(16'h4255, 4'h0, 1);
        check(REGS.mem[12'h055], 8'h4B);
        $display("test reset done");
    endtask

    initial begin
        repeat (8) @(posedge clk_sys);
        #1;
        rstn = 1'b1;
        t_rot_file();
        t_rot_acc();
        t_fill();
        t_ignore();
        t_reset();
        report_and_stop();
    end
endmodule
`default_nettype wire
